/* hdl/ddri_regs.svh */
// Constants of the registered double-data-rate module power-up controller.
// Function
// - Keep clock enable low through power-up with a stable clock before waiting.
// - With clock enable low, wait at least 200 us before the next step.
// - Raise clock enable and issue NOP or DESELECT before any other command.
// - Then issue PRECHARGE ALL closing every bank.
// - After first PRECHARGE ALL wait row precharge time, only NOP or DESELECT.
// - Load extended mode: DLL disable 0, drive strength chosen, higher bits 0.
// - After each mode load wait mode-register set time with only NOP/DESELECT.
// - Load mode register with operating parameters and DLL reset set.
// - Allow at least 200 clocks between DLL-reset load and first READ.
// - Then second PRECHARGE ALL and row precharge wait with only NOP/DESELECT.
// - Two AUTO REFRESH commands, each followed by refresh cycle time wait.
// - Optional mode load clearing DLL reset, same parameters, then set wait.
// - After buffer clear released, hold buffer data inputs low 22 ns.
// - After buffer clear asserted, keep buffer inputs valid for 22 ns.
// - Allow up to 100 ms for clock driver lock before relying on it.
`ifndef DDRI_REGS_SVH
`define DDRI_REGS_SVH

// Command codes as {chip select, row strobe, column strobe, write enable}, all low active.
`define DDRI_CMD_NOP      4'h7
`define DDRI_CMD_PRE      4'h2
`define DDRI_CMD_AREF     4'h1
`define DDRI_CMD_LMR      4'h0
`define DDRI_CMD_RESET    4'h0

// Bank select values and address bit positions.
`define DDRI_BA_MR        2'h0
`define DDRI_BA_EMR       2'h1
`define DDRI_ALL_BANKS_BIT 10
`define DDRI_DLL_RESET_BIT 8
`define DDRI_DRIVE_STRENGTH_BIT 1
`define DDRI_DLL_DISABLE_BIT 0

// Times in their printed units, and the clock period.
`define DDRI_CLK_PERIOD_PS 8000
`define DDRI_T_INIT_US     200
`define DDRI_T_PLL_MS      100
`define DDRI_T_ACT_NS      22
`define DDRI_T_INACT_NS    22
`define DDRI_T_RP_NS       20
`define DDRI_T_MRD_NS      15
`define DDRI_T_RFC_NS      75
`define DDRI_DLL_READ_CYC  200

`endif

/* hdl/ddri_pkg.sv */
// Types shared by the power-up controller modules.
package ddri_pkg;

	// One-hot sequence states.
	typedef enum logic [19:0] {
		S_INACT = 20'h00001,
		S_BUFRST = 20'h00002,
		S_ACT   = 20'h00004,
		S_PWAIT = 20'h00008,
		S_CKE   = 20'h00010,
		S_PRE1  = 20'h00020,
		S_WRP1  = 20'h00040,
		S_EMR   = 20'h00080,
		S_WMR1  = 20'h00100,
		S_MR    = 20'h00200,
		S_WMR2  = 20'h00400,
		S_PRE2  = 20'h00800,
		S_WRP2  = 20'h01000,
		S_REF1  = 20'h02000,
		S_WRF1  = 20'h04000,
		S_REF2  = 20'h08000,
		S_WRF2  = 20'h10000,
		S_MRC   = 20'h20000,
		S_WMR3  = 20'h40000,
		S_READY = 20'h80000
	} ddri_state_e;

endpackage

/* hdl/ddri_tmr_if.sv */
// Interval timer connection between the sequencer and its down counter.
`timescale 1ns/100ps
interface ddri_tmr_if #(parameter int CNT_W = 24);
	logic             load;
	logic [CNT_W-1:0] count;
	logic             lastCycle;

	modport ctrl (output load, output count, input lastCycle);
	modport tmr  (input load, input count, output lastCycle);
endinterface

/* hdl/ddri_wait_timer.sv */
// Down counter that marks the last cycle of a loaded interval.
`timescale 1ns/100ps
module ddri_wait_timer (
	input  wire logic clock,
	input  wire logic rst_n,
	ddri_tmr_if.tmr   tmr
);
	logic [$bits(tmr.count)-1:0] cnt_reg;

	// An interval of N cycles is loaded as N-1; the last cycle shows zero.
	assign tmr.lastCycle = (cnt_reg == '0);

	// Load wins over counting; the count rests at zero.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (tmr.load) begin
			cnt_reg <= tmr.count;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule

/* hdl/ddri_init_ctrl.sv */
// Power-up initialisation sequencer driving a registered double-data-rate memory module.
`timescale 1ns/100ps
`include "ddri_regs.svh"
module ddri_init_ctrl #(
	parameter int ADDR_W        = 13,
	parameter int CNT_W         = 24,
	parameter int T_RP_NS       = `DDRI_T_RP_NS,
	parameter int T_MRD_NS      = `DDRI_T_MRD_NS,
	parameter int T_RFC_NS      = `DDRI_T_RFC_NS,
	parameter int INIT_WAIT_CYC = (`DDRI_T_INIT_US * 1000000 + `DDRI_CLK_PERIOD_PS - 1) / `DDRI_CLK_PERIOD_PS,
	parameter int PLL_LOCK_CYC  = (`DDRI_T_PLL_MS * 1000000 + `DDRI_CLK_PERIOD_PS / 1000 - 1) / (`DDRI_CLK_PERIOD_PS / 1000)
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] modeParams,
	input  wire logic              driveReduced,
	input  wire logic              clearDllReset,
	input  wire logic              shutdownReq,
	output logic                   initDone,
	output logic                   readAllowed,
	output logic                   bufClearN,
	output logic                   cke,
	output logic                   csN,
	output logic                   rasN,
	output logic                   casN,
	output logic                   weN,
	output logic [1:0]             ba,
	output logic [ADDR_W-1:0]      addr
);
	////////////////////////////////////////////////////////////////////////////////
	// Cycle counts, every minimum rounded up to whole clocks.
	localparam int PER_PS    = `DDRI_CLK_PERIOD_PS;
	localparam int ACT_CYC   = (`DDRI_T_ACT_NS * 1000 + PER_PS - 1) / PER_PS;
	localparam int INACT_CYC = (`DDRI_T_INACT_NS * 1000 + PER_PS - 1) / PER_PS;
	localparam int RP_CYC    = (T_RP_NS * 1000 + PER_PS - 1) / PER_PS;
	localparam int MRD_CYC   = (T_MRD_NS * 1000 + PER_PS - 1) / PER_PS;
	localparam int RFC_CYC   = (T_RFC_NS * 1000 + PER_PS - 1) / PER_PS;
	localparam int DLL_CYC   = `DDRI_DLL_READ_CYC;

	// The interval timer needs two cycles per command gap and must hold the longest wait.
	initial begin
		if (ADDR_W <= `DDRI_ALL_BANKS_BIT || RP_CYC < 2 || MRD_CYC < 2 || RFC_CYC < 2 ||
		    ACT_CYC < 1 || INIT_WAIT_CYC < 1 || PLL_LOCK_CYC < 1 ||
		    longint'(PLL_LOCK_CYC) >= (longint'(1) << CNT_W) ||
		    longint'(INIT_WAIT_CYC) >= (longint'(1) << CNT_W)) begin
			$error("ddri_init_ctrl: parameters out of range");
		end
	end

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n - 1);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer.
	ddri_pkg::ddri_state_e state_reg;
	ddri_pkg::ddri_state_e state_next;
	ddri_tmr_if #(.CNT_W(CNT_W)) tmrBus ();
	logic                          tick;

	ddri_wait_timer u_timer (
		.clock (clock),
		.rst_n (rst_n),
		.tmr   (tmrBus.tmr)
	);

	assign tick = tmrBus.lastCycle;

	// Next state; each wait leaves on the timer's last cycle.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ddri_pkg::S_INACT: if (tick) state_next = ddri_pkg::S_BUFRST;
			ddri_pkg::S_BUFRST: if (tick) state_next = ddri_pkg::S_ACT;
			ddri_pkg::S_ACT:   if (tick) state_next = ddri_pkg::S_PWAIT;
			ddri_pkg::S_PWAIT: if (tick) state_next = ddri_pkg::S_CKE;
			ddri_pkg::S_CKE:   state_next = ddri_pkg::S_PRE1;
			ddri_pkg::S_PRE1:  state_next = ddri_pkg::S_WRP1;
			ddri_pkg::S_WRP1:  if (tick) state_next = ddri_pkg::S_EMR;
			ddri_pkg::S_EMR:   state_next = ddri_pkg::S_WMR1;
			ddri_pkg::S_WMR1:  if (tick) state_next = ddri_pkg::S_MR;
			ddri_pkg::S_MR:    state_next = ddri_pkg::S_WMR2;
			ddri_pkg::S_WMR2:  if (tick) state_next = ddri_pkg::S_PRE2;
			ddri_pkg::S_PRE2:  state_next = ddri_pkg::S_WRP2;
			ddri_pkg::S_WRP2:  if (tick) state_next = ddri_pkg::S_REF1;
			ddri_pkg::S_REF1:  state_next = ddri_pkg::S_WRF1;
			ddri_pkg::S_WRF1:  if (tick) state_next = ddri_pkg::S_REF2;
			ddri_pkg::S_REF2:  state_next = ddri_pkg::S_WRF2;
			ddri_pkg::S_WRF2: begin
				if (tick) state_next = clearDllReset ? ddri_pkg::S_MRC : ddri_pkg::S_READY;
			end
			ddri_pkg::S_MRC:   state_next = ddri_pkg::S_WMR3;
			ddri_pkg::S_WMR3:  if (tick) state_next = ddri_pkg::S_READY;
			ddri_pkg::S_READY: if (shutdownReq) state_next = ddri_pkg::S_INACT;
			default:           state_next = ddri_pkg::S_INACT;
		endcase
	end

	// Timer reload on entry to a timed state or a command that opens a gap.
	// A wait state entered after its command keeps running the command's count, so the gap is not cut short.
	logic enter;
	logic waitNext;
	assign enter = (state_next != state_reg);
	assign waitNext = (state_next == ddri_pkg::S_WRP1 || state_next == ddri_pkg::S_WMR1 ||
	                   state_next == ddri_pkg::S_WMR2 || state_next == ddri_pkg::S_WRP2 ||
	                   state_next == ddri_pkg::S_WRF1 || state_next == ddri_pkg::S_WRF2 ||
	                   state_next == ddri_pkg::S_WMR3);
	assign tmrBus.load = enter && !waitNext;
	assign tmrBus.count =
		(state_next == ddri_pkg::S_INACT)  ? cyc(INACT_CYC) :
		(state_next == ddri_pkg::S_BUFRST) ? cyc(PLL_LOCK_CYC) :
		(state_next == ddri_pkg::S_ACT)    ? cyc(ACT_CYC) :
		(state_next == ddri_pkg::S_PWAIT)  ? cyc(INIT_WAIT_CYC) :
		(state_next == ddri_pkg::S_PRE1 || state_next == ddri_pkg::S_PRE2) ? cyc(RP_CYC) :
		(state_next == ddri_pkg::S_REF1 || state_next == ddri_pkg::S_REF2) ? cyc(RFC_CYC) :
		(state_next == ddri_pkg::S_EMR || state_next == ddri_pkg::S_MR ||
		 state_next == ddri_pkg::S_MRC)    ? cyc(MRD_CYC) : '0;

	// State register; reset starts with the buffer clear held and inputs valid.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ddri_pkg::S_INACT;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin values for the coming state, registered so pins track the state.
	logic [3:0]        cmd_next;
	logic [1:0]        ba_next;
	logic [ADDR_W-1:0] addr_next;
	logic              cke_next;
	logic              clr_next;
	logic [ADDR_W-1:0] emrWord;
	logic [ADDR_W-1:0] mrBase;

	// Extended mode word: DLL enabled, chosen drive, higher bits zero.
	assign emrWord = ADDR_W'({driveReduced, 1'b0});
	assign mrBase  = modeParams & ~(ADDR_W'(1) << `DDRI_DLL_RESET_BIT);

	// Buffer inputs low while its clear is released; clock enable low until the wait ends.
	assign clr_next = !(state_next == ddri_pkg::S_INACT || state_next == ddri_pkg::S_BUFRST);
	assign cke_next = !(state_next == ddri_pkg::S_INACT || state_next == ddri_pkg::S_BUFRST ||
	                    state_next == ddri_pkg::S_ACT || state_next == ddri_pkg::S_PWAIT);
	assign cmd_next =
		(state_next == ddri_pkg::S_ACT || state_next == ddri_pkg::S_BUFRST) ? `DDRI_CMD_RESET :
		(state_next == ddri_pkg::S_PRE1 || state_next == ddri_pkg::S_PRE2) ? `DDRI_CMD_PRE :
		(state_next == ddri_pkg::S_REF1 || state_next == ddri_pkg::S_REF2) ? `DDRI_CMD_AREF :
		(state_next == ddri_pkg::S_EMR || state_next == ddri_pkg::S_MR ||
		 state_next == ddri_pkg::S_MRC) ? `DDRI_CMD_LMR : `DDRI_CMD_NOP;
	assign ba_next = (state_next == ddri_pkg::S_EMR) ? `DDRI_BA_EMR : `DDRI_BA_MR;
	assign addr_next =
		(state_next == ddri_pkg::S_PRE1 || state_next == ddri_pkg::S_PRE2) ?
			(ADDR_W'(1) << `DDRI_ALL_BANKS_BIT) :
		(state_next == ddri_pkg::S_EMR) ? emrWord :
		(state_next == ddri_pkg::S_MR)  ? (mrBase | (ADDR_W'(1) << `DDRI_DLL_RESET_BIT)) :
		(state_next == ddri_pkg::S_MRC) ? mrBase : '0;

	// Output pin flops.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{csN, rasN, casN, weN} <= `DDRI_CMD_NOP;
			ba        <= '0;
			addr      <= '0;
			cke       <= 1'b0;
			bufClearN <= 1'b0;
		end else begin
			{csN, rasN, casN, weN} <= cmd_next;
			ba        <= ba_next;
			addr      <= addr_next;
			cke       <= cke_next;
			bufClearN <= clr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Completion and DLL-reset to READ spacing.
	logic [7:0] dllCnt_reg;

	// Counts cycles since the DLL-reset load, saturating.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dllCnt_reg  <= '0;
			initDone    <= 1'b0;
			readAllowed <= 1'b0;
		end else begin
			if (state_reg == ddri_pkg::S_MR) begin
				dllCnt_reg <= 8'h01;
			end else if (dllCnt_reg < 8'(DLL_CYC)) begin
				dllCnt_reg <= dllCnt_reg + 8'h01;
			end
			initDone    <= (state_next == ddri_pkg::S_READY);
			readAllowed <= (state_next == ddri_pkg::S_READY) && (dllCnt_reg >= 8'(DLL_CYC - 1));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the pins, with helper history of issued commands.
	logic [3:0]  pinCmd;
	logic        issue;
	logic [3:0]  lastCmd_reg;
	logic [15:0] gap_reg;
	logic [23:0] lowRun_reg;
	logic        mrSeen_reg;

	assign pinCmd = {csN, rasN, casN, weN};
	assign issue  = cke && bufClearN && (pinCmd != `DDRI_CMD_NOP) && !csN;

	// Gap since the last command, clock-enable-low run length, DLL-reset load seen.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lastCmd_reg <= `DDRI_CMD_NOP;
			gap_reg     <= '0;
			lowRun_reg  <= '0;
			mrSeen_reg  <= 1'b0;
		end else begin
			lastCmd_reg <= issue ? pinCmd : lastCmd_reg;
			gap_reg     <= issue ? 16'h0001 : (gap_reg == 16'hffff ? gap_reg : gap_reg + 16'h0001);
			lowRun_reg  <= (cke || !bufClearN) ? '0 : lowRun_reg + 24'h000001;
			mrSeen_reg  <= bufClearN && (mrSeen_reg || (issue && pinCmd == `DDRI_CMD_LMR &&
			                              ba == `DDRI_BA_MR && addr[`DDRI_DLL_RESET_BIT]));
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence clrReleased;
		$rose(bufClearN);
	endsequence

	a_init_wait_len: assert property ($rose(cke) |-> lowRun_reg >= 24'(INIT_WAIT_CYC))
		else $error("clock enable raised before the power-up wait");
	a_cke_low_early: assert property (!bufClearN |-> !cke)
		else $error("clock enable high while the buffer is cleared");
	a_first_cmd_nop: assert property ($rose(cke) |-> pinCmd == `DDRI_CMD_NOP)
		else $error("first command after clock enable is not NOP");
	a_pre_all_banks: assert property (issue && pinCmd == `DDRI_CMD_PRE |-> addr[`DDRI_ALL_BANKS_BIT])
		else $error("precharge without all-banks bit");
	a_rp_gap_kept: assert property (issue && lastCmd_reg == `DDRI_CMD_PRE |-> gap_reg >= 16'(RP_CYC))
		else $error("row precharge time violated");
	a_mrd_gap_kept: assert property (issue && lastCmd_reg == `DDRI_CMD_LMR |-> gap_reg >= 16'(MRD_CYC))
		else $error("mode register set time violated");
	a_rfc_gap_kept: assert property (issue && lastCmd_reg == `DDRI_CMD_AREF |-> gap_reg >= 16'(RFC_CYC))
		else $error("refresh cycle time violated");
	a_emr_word_ok: assert property (issue && pinCmd == `DDRI_CMD_LMR && ba == `DDRI_BA_EMR
		|-> addr == ADDR_W'({driveReduced, 1'b0}))
		else $error("extended mode word has wrong bits");
	a_mr_dll_reset: assert property ($rose(mrSeen_reg) |-> state_reg == ddri_pkg::S_WMR2)
		else $error("DLL-reset load out of sequence");
	a_read_spacing: assert property ($rose(readAllowed) |-> $past(mrSeen_reg, 199))
		else $error("read allowed too soon after DLL reset");
	a_act_inputs_low: assert property (clrReleased |-> (pinCmd == `DDRI_CMD_RESET && addr == '0)[*3])
		else $error("buffer inputs not held low after clear release");
	a_inact_valid: assert property ($fell(bufClearN) |-> (!cke && pinCmd == `DDRI_CMD_NOP)[*3])
		else $error("buffer inputs not held valid after clear");
endmodule

/* verif/ddri_mem_model.sv */
// Memory module model that decodes initialisation commands and counts timing faults.
`timescale 1ns/100ps
`include "ddri_regs.svh"
module ddri_mem_model #(
	parameter int INIT_WAIT_CYC = 20,
	parameter int PLL_LOCK_CYC  = 30
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        bufClearN,
	input  wire logic        cke,
	input  wire logic        csN,
	input  wire logic        rasN,
	input  wire logic        casN,
	input  wire logic        weN,
	input  wire logic [1:0]  ba,
	input  wire logic [12:0] addr,
	output logic             evValid,
	output logic [3:0]       evCmd,
	output logic [1:0]       evBa,
	output logic [12:0]      evAddr,
	output int               evGap,
	output int               sinceCmd,
	output int               mrAge,
	output int               errCnt
);
	////////////////////////////////////////////////////////////////////////////////
	// Minimum waits in whole cycles, rounded up.
	localparam int PS = `DDRI_CLK_PERIOD_PS;
	localparam int RP_CYC  = (`DDRI_T_RP_NS * 1000 + PS - 1) / PS;
	localparam int MRD_CYC = (`DDRI_T_MRD_NS * 1000 + PS - 1) / PS;
	localparam int RFC_CYC = (`DDRI_T_RFC_NS * 1000 + PS - 1) / PS;
	logic [3:0] cmdNow;
	logic [3:0] lastCmd;
	int         cyc;
	int         lastCyc;
	int         lowCnt;
	int         actCnt;
	int         inactCnt;
	int         need;

	// Decode of the pins and of the wait owed to the previous command.
	assign cmdNow = {csN, rasN, casN, weN};
	assign sinceCmd = cyc - lastCyc;
	assign need = (lastCmd == `DDRI_CMD_PRE) ? RP_CYC : (lastCmd == `DDRI_CMD_LMR) ? MRD_CYC :
		(lastCmd == `DDRI_CMD_AREF) ? RFC_CYC : 1;

	////////////////////////////////////////////////////////////////////////////////
	// Samples the pins each edge; any selected command after clock enable is accepted.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{cyc, lastCyc, lowCnt, actCnt, inactCnt, mrAge, errCnt} <= '0;
			evValid <= 1'b0;
			lastCmd <= `DDRI_CMD_NOP;
		end else begin
			cyc <= cyc + 1;
			mrAge <= mrAge + 1;
			evValid <= 1'b0;
			lowCnt <= cke ? 0 : lowCnt + 1;
			actCnt <= bufClearN ? actCnt + 1 : 0;
			inactCnt <= bufClearN ? 0 : inactCnt + 1;
			if (bufClearN && actCnt < 3 && {cmdNow, ba, addr} !== '0)
				errCnt <= errCnt + 1;
			if (!bufClearN && inactCnt < 3 && $isunknown({cmdNow, ba, addr}))
				errCnt <= errCnt + 1;
			if (cke && lowCnt != 0) begin
				lastCyc <= cyc;
				lastCmd <= `DDRI_CMD_NOP;
				if (lowCnt < PLL_LOCK_CYC + INIT_WAIT_CYC || cmdNow != `DDRI_CMD_NOP)
					errCnt <= errCnt + 1;
			end else if (cke && !csN && cmdNow != `DDRI_CMD_NOP) begin
				evValid <= 1'b1;
				{evCmd, evBa, evAddr} <= {cmdNow, ba, addr};
				evGap <= cyc - lastCyc;
				lastCyc <= cyc;
				lastCmd <= cmdNow;
				if (cyc - lastCyc < need)
					errCnt <= errCnt + 1;
				if (cmdNow == `DDRI_CMD_LMR && ba == `DDRI_BA_MR && addr[`DDRI_DLL_RESET_BIT])
					mrAge <= 0;
			end
		end
	end
endmodule

/* verif/ddri_init_ctrl_tb.sv */
// Self-checking testbench of the power-up sequencer against the memory model.
`timescale 1ns/100ps
`include "ddri_regs.svh"
module ddri_init_ctrl_tb;
	typedef struct {logic [3:0] cmd; logic [1:0] ba; logic [12:0] addr; int gap; bit atLeast;} ddri_exp_s;
	localparam int PS = `DDRI_CLK_PERIOD_PS;
	localparam int RP_CYC  = (`DDRI_T_RP_NS * 1000 + PS - 1) / PS;
	localparam int MRD_CYC = (`DDRI_T_MRD_NS * 1000 + PS - 1) / PS;
	localparam int RFC_CYC = (`DDRI_T_RFC_NS * 1000 + PS - 1) / PS;
	logic clock, rst_n, driveReduced, clearDllReset, shutdownReq, initDone, readAllowed;
	logic bufClearN, cke, csN, rasN, casN, weN, evValid;
	logic [12:0] modeParams, addr, evAddr, mode;
	logic [1:0]  ba, evBa;
	logic [3:0]  evCmd;
	logic        drive;
	int          evGap, sinceCmd, mrAge, errCnt, n_fail, total_checks, cycles, readyGap;
	bit          doneSeen, readSeen;
	ddri_exp_s   expQ[$];
	ddri_exp_s   expHead;

	////////////////////////////////////////////////////////////////////////////////
	// Clock, design and memory model; long waits shortened for simulation.
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	ddri_init_ctrl #(.INIT_WAIT_CYC(20), .PLL_LOCK_CYC(30)) u_ddri_init_ctrl (.clock(clock), .rst_n(rst_n),
		.modeParams(modeParams), .driveReduced(driveReduced), .clearDllReset(clearDllReset),
		.shutdownReq(shutdownReq), .initDone(initDone), .readAllowed(readAllowed), .bufClearN(bufClearN),
		.cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .ba(ba), .addr(addr));
	ddri_mem_model #(.INIT_WAIT_CYC(20), .PLL_LOCK_CYC(30)) u_ddri_mem_model (.clock(clock), .rst_n(rst_n),
		.bufClearN(bufClearN), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .ba(ba),
		.addr(addr), .evValid(evValid), .evCmd(evCmd), .evBa(evBa), .evAddr(evAddr), .evGap(evGap),
		.sinceCmd(sinceCmd), .mrAge(mrAge), .errCnt(errCnt));

	////////////////////////////////////////////////////////////////////////////////
	// Compare tasks and the closing report.
	task automatic checkVal(input string what, input logic [31:0] expVal, input logic [31:0] gotVal);
		total_checks++;
		if (gotVal !== expVal) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, expVal, gotVal);
		end
	endtask
	task automatic checkMin(input string what, input int minVal, input int gotVal);
		total_checks++;
		if (gotVal < minVal) begin
			n_fail++;
			$display("ERROR %s expected at least %0d seen %0d", what, minVal, gotVal);
		end
	endtask
	task automatic pushCmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input int g, input bit m);
		expQ.push_back('{c, b, a, g, m});
	endtask
	task test_done;
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watcher: each decoded command is compared with the oldest note, on settled values.
	always @(negedge clock) begin
		if (evValid === 1'b1) begin
			if (expQ.size() == 0) begin
				checkVal("unexpected command", 32'h0, 32'h1);
			end else begin
				expHead = expQ.pop_front();
				checkVal("command", {expHead.ba, expHead.addr, expHead.cmd}, {evBa, evAddr, evCmd});
				if (expHead.atLeast)
					checkMin("first command gap", expHead.gap, evGap);
				else
					checkVal("command gap", expHead.gap, evGap);
			end
		end
		if (initDone === 1'b1 && !doneSeen) begin
			doneSeen = 1'b1;
			checkMin("ready gap", readyGap, sinceCmd);
			checkVal("commands left at ready", 32'h0, expQ.size());
		end
		if (readAllowed === 1'b1 && !readSeen) begin
			readSeen = 1'b1;
			checkMin("dll reset age", `DDRI_DLL_READ_CYC, mrAge + 1);
			checkVal("ready with read", 32'h1, {31'h0, initDone});
		end
	end

	// Timeout: a hang is cut short and counted.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			checkVal("timeout", 32'h0, 32'h1);
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: two power-ups, with and without the final mode load, each ended by a shutdown.
	initial begin
		void'($urandom(32'h6052));
		{rst_n, driveReduced, clearDllReset, shutdownReq, doneSeen, readSeen} = '0;
		modeParams = '0;
		{n_fail, total_checks, cycles} = '0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		for (int run = 0; run < 2; run++) begin
			@(posedge clock);
			mode = 13'($urandom);
			drive = 1'($urandom);
			modeParams <= mode;
			driveReduced <= drive;
			clearDllReset <= (run == 0);
			readyGap = (run == 0) ? MRD_CYC : RFC_CYC;
			pushCmd(`DDRI_CMD_PRE, 2'h0, 13'h400, 1, 1'b1);
			pushCmd(`DDRI_CMD_LMR, `DDRI_BA_EMR, {11'h0, drive, 1'b0}, RP_CYC, 1'b0);
			pushCmd(`DDRI_CMD_LMR, `DDRI_BA_MR, mode | 13'h100, MRD_CYC, 1'b0);
			pushCmd(`DDRI_CMD_PRE, 2'h0, 13'h400, MRD_CYC, 1'b0);
			pushCmd(`DDRI_CMD_AREF, 2'h0, 13'h0, RP_CYC, 1'b0);
			pushCmd(`DDRI_CMD_AREF, 2'h0, 13'h0, RFC_CYC, 1'b0);
			if (run == 0)
				pushCmd(`DDRI_CMD_LMR, `DDRI_BA_MR, mode & ~13'h100, RFC_CYC, 1'b0);
			for (int i = 0; i < 1000 && readAllowed !== 1'b1; i++)
				@(posedge clock);
			checkVal("read allowed", 32'h1, {31'h0, readAllowed});
			shutdownReq <= 1'b1;
			@(posedge clock);
			shutdownReq <= 1'b0;
			repeat (2) @(posedge clock);
			#1;
			checkVal("shutdown outputs", 32'h0, {cke, bufClearN, initDone, readAllowed});
			doneSeen = 1'b0;
			readSeen = 1'b0;
		end
		repeat (5) @(posedge clock);
		checkVal("model faults", 32'h0, errCnt);
		checkVal("commands left", 32'h0, expQ.size());
		test_done();
	end
endmodule
